// ---- hdl/idu_defines.vh ----
// Purpose: Constants for the upper identification word bank
// Assumes: Included by bare name from the design files
// Notes: Word indices are 16-bit word numbers of the 256-word block
`ifndef IDU_DEFINES_VH
`define IDU_DEFINES_VH

// ------------------------------------------------------------
// Word indices
// ------------------------------------------------------------
`define IDU_W_GENCFG 8'h00
`define IDU_W_RESET 8'h5D
`define IDU_W_AAM 8'h5E
`define IDU_W_LBA0 8'h64
`define IDU_W_LBA1 8'h65
`define IDU_W_LBA2 8'h66
`define IDU_W_LBA3 8'h67
`define IDU_W_RMSN 8'h7F
`define IDU_W_SEC 8'h80
`define IDU_W_CFA 8'hA0
`define IDU_W_MSN_FIRST 8'hB0
`define IDU_W_MSN_LAST 8'hCD
`define IDU_W_INTEG 8'hFF
`define IDU_W_UPPER_FIRST 8'h5D

// ------------------------------------------------------------
// Fixed values
// ------------------------------------------------------------
`define IDU_GENCFG_VAL 16'h0040
`define IDU_RMSN_VAL 16'h0000
`define IDU_SIGNATURE 8'hA5
`define IDU_ZERO16 16'h0000
`define IDU_ZERO8 8'h00
`define IDU_ZERO13 13'h0000
`define IDU_ZERO5 5'h00
`define IDU_ZERO2 2'h0
`define IDU_ZERO7 7'h00
`define IDU_ONE1 1'h1
`define IDU_ZERO1 1'h0

// ------------------------------------------------------------
// Device number method codes
// ------------------------------------------------------------
`define IDU_METH_RSVD 2'h0
`define IDU_METH_JUMPER 2'h1
`define IDU_METH_CSEL 2'h2
`define IDU_METH_OTHER 2'h3

`endif

// ---- hdl/idu_pin_sync.v ----
// Purpose: Three-stage synchroniser with agreement filter for one pin
// Assumes: Pin is asynchronous to mclk
// Notes: Output follows only when stages two and three agree
`timescale 1ns/1ps
`include "idu_defines.vh"

module idu_pin_sync (
	input wire mclk,
	input wire rstn,
	input wire ce,
	input wire pinIn,
	output reg levelOut
);

reg stage1_reg;
reg stage2_reg;
reg stage3_reg;

// ------------------------------------------------------------
// Capture chain
// ------------------------------------------------------------
// Stage one feeds stage two only, never the filter
always @(posedge mclk or negedge rstn) begin
	if (!rstn) begin
		stage1_reg <= `IDU_ZERO1;
		stage2_reg <= `IDU_ZERO1;
		stage3_reg <= `IDU_ZERO1;
		levelOut <= `IDU_ZERO1;
	end else if (ce) begin
		stage1_reg <= pinIn;
		stage2_reg <= stage1_reg;
		stage3_reg <= stage2_reg;
		if (stage2_reg == stage3_reg) begin
			levelOut <= stage3_reg;
		end
	end
end

endmodule // idu_pin_sync

// ---- hdl/idu_word_bank.v ----
// Purpose: Upper identification words 93..255 plus word 0, read one word at a time
// Assumes: Configuration inputs come from logic on mclk; cable, PDIAG and DASP are pins
// Notes: Read data appear one cycle after the request; checksum is recomputed every cycle
`timescale 1ns/1ps
`include "idu_defines.vh"

// How it works
// - Bit 13 reports sensed cable-identification level
// - Device 0 clears bits 12-8
// - Device 1 bit 11 shows own PDIAG drive
// - Device 1 bits 10-9 give numbering method
// - Device 1 clears bits 7-0
// - Device 0 bit 6 shows response policy
// - Device 0 bit 5 shows DASP seen
// - Device 0 bit 4 shows PDIAG seen
// - Device 0 bit 3 shows diagnostic pass
// - Device 0 bits 2-1 give numbering method
// - Acoustic word: recommended high, current low
// - Four words hold 48-bit maximum LBA
// - Removable notification word reads zero
// - Security word: level bit 8, flags 5-0
// - CFA word: valid, required, disabled, current
// - Media serial number words read zero
// - Last word: checksum high, A5 low
// - General configuration word reads 0040h
// - Bits 12-0 change only during hardware reset
module idu_word_bank (
	input wire mclk,
	input wire rstn,
	input wire ce,
	input wire hwResetActive,
	input wire isDevice1,
	input wire [1:0] numberMethod,
	input wire drovePdiag,
	input wire respondsForDev1,
	input wire diagPassed,
	input wire cableIdPin,
	input wire pdiagPinN,
	input wire daspPinN,
	input wire [7:0] aamRecommended,
	input wire [7:0] aamCurrent,
	input wire [47:0] maxLba48,
	input wire securityLevelMax,
	input wire [5:0] securityFlags,
	input wire cfaWordValid,
	input wire cfaRequired,
	input wire cfaDisabled,
	input wire [11:0] cfaMaxCurrent,
	input wire [7:0] otherByteSum,
	input wire rdReq,
	input wire [7:0] rdWord,
	output reg [15:0] rdData,
	output reg rdValid,
	output reg [15:0] resetResultWord
);

// ------------------------------------------------------------
// Pin synchronisers
// ------------------------------------------------------------
wire cableIdLevel;
wire pdiagLevelN;
wire daspLevelN;

idu_pin_sync uSyncCable (
	.mclk(mclk),
	.rstn(rstn),
	.ce(ce),
	.pinIn(cableIdPin),
	.levelOut(cableIdLevel)
);

idu_pin_sync uSyncPdiag (
	.mclk(mclk),
	.rstn(rstn),
	.ce(ce),
	.pinIn(pdiagPinN),
	.levelOut(pdiagLevelN)
);

idu_pin_sync uSyncDasp (
	.mclk(mclk),
	.rstn(rstn),
	.ce(ce),
	.pinIn(daspPinN),
	.levelOut(daspLevelN)
);

// ------------------------------------------------------------
// Reset result capture
// ------------------------------------------------------------
reg [12:0] resultLow_reg;
reg [12:0] resultLow_next;
reg cableBit_reg;
reg [7:0] checksum_reg;
reg [7:0] checksum_next;
reg [7:0] ownSum;
reg [15:0] wordSel;

always @* begin
	resultLow_next = `IDU_ZERO13;
	if (isDevice1) begin
		resultLow_next[12] = `IDU_ZERO1;
		resultLow_next[11] = drovePdiag;
		resultLow_next[10:9] = numberMethod;
		resultLow_next[8] = `IDU_ONE1;
		resultLow_next[7:0] = `IDU_ZERO8;
	end else begin
		resultLow_next[12:8] = `IDU_ZERO5;
		resultLow_next[7] = `IDU_ZERO1;
		resultLow_next[6] = respondsForDev1;
		resultLow_next[5] = ~daspLevelN;
		resultLow_next[4] = ~pdiagLevelN;
		resultLow_next[3] = diagPassed;
		resultLow_next[2:1] = numberMethod;
		resultLow_next[0] = `IDU_ONE1;
	end
end

// Low bits freeze outside reset so software sees a stable snapshot
always @(posedge mclk or negedge rstn) begin
	if (!rstn) begin
		resultLow_reg <= `IDU_ZERO13;
		cableBit_reg <= `IDU_ZERO1;
	end else if (ce) begin
		cableBit_reg <= cableIdLevel;
		if (hwResetActive) begin
			resultLow_reg <= resultLow_next;
		end
	end
end

wire [15:0] genCfgWord = `IDU_GENCFG_VAL;
wire [15:0] resetWordNow = {`IDU_ZERO1, `IDU_ONE1, cableBit_reg, resultLow_reg};
wire [15:0] aamWord = {aamRecommended, aamCurrent};
wire [15:0] secWord = {`IDU_ZERO7, securityLevelMax, `IDU_ZERO2, securityFlags};
wire [15:0] cfaWord = {cfaWordValid, `IDU_ZERO1, cfaRequired, cfaDisabled, cfaMaxCurrent};

// ------------------------------------------------------------
// Checksum
// ------------------------------------------------------------
// Lower feature words are summed elsewhere and arrive as one byte
always @* begin
	ownSum = otherByteSum;
	ownSum = ownSum + genCfgWord[15:8] + genCfgWord[7:0];
	ownSum = ownSum + resetWordNow[15:8] + resetWordNow[7:0];
	ownSum = ownSum + aamWord[15:8] + aamWord[7:0];
	ownSum = ownSum + maxLba48[47:40] + maxLba48[39:32] + maxLba48[31:24];
	ownSum = ownSum + maxLba48[23:16] + maxLba48[15:8] + maxLba48[7:0];
	ownSum = ownSum + secWord[15:8] + secWord[7:0];
	ownSum = ownSum + cfaWord[15:8] + cfaWord[7:0];
	ownSum = ownSum + `IDU_SIGNATURE;
	checksum_next = `IDU_ZERO8 - ownSum;
end

always @(posedge mclk or negedge rstn) begin
	if (!rstn) begin
		checksum_reg <= `IDU_ZERO8;
	end else if (ce) begin
		checksum_reg <= checksum_next;
	end
end

// ------------------------------------------------------------
// Word select
// ------------------------------------------------------------
// Checksum lags inputs by one cycle; hold inputs steady before reading
always @* begin
	case (rdWord)
		`IDU_W_GENCFG: wordSel = `IDU_GENCFG_VAL;
		`IDU_W_RESET: wordSel = resetWordNow;
		`IDU_W_AAM: wordSel = aamWord;
		`IDU_W_LBA0: wordSel = maxLba48[15:0];
		`IDU_W_LBA1: wordSel = maxLba48[31:16];
		`IDU_W_LBA2: wordSel = maxLba48[47:32];
		`IDU_W_LBA3: wordSel = `IDU_ZERO16;
		`IDU_W_RMSN: wordSel = `IDU_RMSN_VAL;
		`IDU_W_SEC: wordSel = secWord;
		`IDU_W_CFA: wordSel = cfaWord;
		`IDU_W_INTEG: wordSel = {checksum_reg, `IDU_SIGNATURE};
		default: wordSel = `IDU_ZERO16;
	endcase
end

// ------------------------------------------------------------
// Output registers
// ------------------------------------------------------------
always @(posedge mclk or negedge rstn) begin
	if (!rstn) begin
		rdData <= `IDU_ZERO16;
		rdValid <= `IDU_ZERO1;
		resetResultWord <= `IDU_ZERO16;
	end else if (ce) begin
		rdValid <= rdReq;
		resetResultWord <= resetWordNow;
		if (rdReq) begin
			rdData <= wordSel;
		end
	end
end

endmodule // idu_word_bank

// ---- sim/idu_word_bank_asserts.sv ----
// Purpose: Checker for idu_word_bank
// Assumes: Pins steady 7 cycles before capture
// Notes: Pin checks skip synchroniser settling
`timescale 1ns/1ps
module idu_word_bank_asserts (
	input wire mclk, rstn, ce, hwResetActive, isDevice1, drovePdiag, respondsForDev1,
	input wire diagPassed, cableIdPin, pdiagPinN, daspPinN, rdReq, rdValid,
	input wire [1:0] numberMethod,
	input wire [7:0] rdWord,
	input wire [15:0] rdData, resetResultWord
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	wire [15:0] r = resetResultWord;
	wire ld = ce && hwResetActive;
	wire rd = ce && rdReq;
	a_cable_level: assert property ((ce && $stable(cableIdPin))[*7] |=> r[13] == $past(cableIdPin))
		else $error("cable bit");
	// Captured bits reach the output port one enabled edge after the load
	a_dev0_clear: assert property (ld && !isDevice1 ##1 ce |=> r[12:7] == 6'h00 && r[0])
		else $error("dev0 clear");
	a_dev0_fields: assert property (ld && !isDevice1 ##1 ce |=>
		{r[6], r[3:1]} == $past({respondsForDev1, diagPassed, numberMethod}, 2))
		else $error("dev0 fields");
	a_dev0_pins: assert property ((ce && $stable({pdiagPinN, daspPinN}))[*7] ##0 ld && !isDevice1 ##1 ce |=>
		r[5:4] == ~$past({daspPinN, pdiagPinN}, 2))
		else $error("dev0 pins");
	a_dev1_fields: assert property (ld && isDevice1 ##1 ce |=>
		r[12:0] == {1'b0, $past(drovePdiag, 2), $past(numberMethod, 2), 9'h100})
		else $error("dev1 fields");
	a_hold_low: assert property (!ld ##1 !ld |=> $stable(r[12:0]))
		else $error("low bits moved");
	a_sig_byte: assert property (rd && rdWord == 8'hFF |=> rdValid && rdData[7:0] == 8'hA5)
		else $error("signature");
	a_gen_cfg: assert property (rd && rdWord == 8'h00 |=> rdData == 16'h0040)
		else $error("word 0");
	a_serial_zero: assert property (rd && rdWord >= 8'hB0 && rdWord <= 8'hCD |=> rdData == 16'h0000)
		else $error("serial");
	c_dev0: cover property (ld && !isDevice1);
	c_dev1: cover property (ld && isDevice1);
	c_sum: cover property (rd && rdWord == 8'hFF);
endmodule // idu_word_bank_asserts
bind idu_word_bank idu_word_bank_asserts chk (.*);

// ---- sim/idu_host_model.sv ----
// Purpose: Host adapter model reading words
// Assumes: Answer one cycle after the request is taken
// Notes: Index is inverted when idle so stale values never help
`timescale 1ns/1ps
module idu_host_model (
	input wire mclk,
	input wire rdValid,
	input wire [15:0] rdData,
	output logic rdReq,
	output logic [7:0] rdWord
);
	initial begin
		rdReq = 1'b0;
		rdWord = 8'h00;
	end
	task automatic rd(input logic [7:0] w, output logic [15:0] d, output logic ok);
		integer i;
		@(posedge mclk);
		rdReq <= 1'b1;
		rdWord <= w;
		@(posedge mclk);
		rdReq <= 1'b0;
		rdWord <= ~w;
		ok = 1'b0;
		d = 16'h0000;
		for (i = 0; i < 3 && !ok; i++) begin
			#1 ok = (rdValid === 1'b1);
			d = rdData;
			if (!ok) @(posedge mclk);
		end
	endtask
endmodule // idu_host_model

// ---- sim/identify_data_upper_words_test.sv ----
// Purpose: Self-checking bench for idu_word_bank
// Assumes: Inputs move by non-blocking assignment at rising mclk
// Notes: Capture waits 8 cycles so synced pins settle
`timescale 1ns/1ps
module identify_data_upper_words_test;
	logic mclk = 1'b0, rstn = 1'b0, ce = 1'b1, hwResetActive = 1'b0, isDevice1 = 1'b0, drovePdiag = 1'b0;
	logic respondsForDev1 = 1'b0, diagPassed = 1'b0, cableIdPin = 1'b0, pdiagPinN = 1'b1, daspPinN = 1'b1;
	logic securityLevelMax = 1'b0, cfaWordValid = 1'b0, cfaRequired = 1'b0, cfaDisabled = 1'b0;
	logic [1:0] numberMethod = 2'h1;
	logic [7:0] aamRecommended = 8'h00, aamCurrent = 8'h00, otherByteSum = 8'h00, rdWord, acc;
	logic [5:0] securityFlags = 6'h00;
	logic [11:0] cfaMaxCurrent = 12'h000;
	logic [47:0] maxLba48 = 48'h0000_0000_0000;
	logic [15:0] rdData, resetResultWord, d, expRr;
	logic rdReq, rdValid, ok;
	integer num_errors = 0, total_checks = 0;
	idu_word_bank uut (.*);
	idu_host_model host (.*);
	initial forever #5 mclk = ~mclk;
	task chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rdChk(input logic [7:0] w, input logic [15:0] e);
		host.rd(w, d, ok);
		if (ok !== 1'b1) d = ~e;
		chk(d, e);
	endtask
	task automatic capture;
		repeat (8) @(posedge mclk);
		hwResetActive <= 1'b1;
		@(posedge mclk);
		hwResetActive <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
	endtask
	task automatic t_dev0;
		@(posedge mclk);
		{cableIdPin, isDevice1, respondsForDev1, diagPassed, pdiagPinN, daspPinN, numberMethod} <= 8'hB5;
		capture;
		expRr = 16'h605B;
		chk(resetResultWord, expRr);
		{respondsForDev1, diagPassed, numberMethod} <= 4'h0;
		repeat (3) @(posedge mclk);
		#1 chk(resetResultWord, expRr);
		rdChk(8'h5D, expRr);
		$display("dev0 done");
	endtask
	task automatic t_dev1;
		integer m;
		for (m = 1; m < 4; m++) begin
			@(posedge mclk);
			{isDevice1, drovePdiag, numberMethod} <= {1'b1, m[0], m[1:0]};
			capture;
			expRr = {3'h3, 1'b0, m[0], m[1:0], 1'b1, 8'h00};
			chk(resetResultWord, expRr);
		end
		$display("dev1 done");
	endtask
	task automatic t_freeze;
		@(posedge mclk);
		{ce, hwResetActive, isDevice1} <= 3'h2;
		repeat (4) @(posedge mclk);
		{ce, hwResetActive} <= 2'h2;
		#1 chk(resetResultWord, expRr);
		$display("freeze done");
	endtask
	task automatic t_words;
		logic [7:0] w [13];
		logic [15:0] e [13];
		w = '{8'h00, 8'h5D, 8'h5E, 8'h64, 8'h65, 8'h66, 8'h67, 8'h7F, 8'h80, 8'hA0, 8'hB0, 8'hCD, 8'hFE};
		e = '{16'h0040, expRr, 16'h80FE, 16'h9ABC, 16'h5678, 16'h1234, 16'h0000, 16'h0000,
			16'h012A, 16'hA0F5, 16'h0000, 16'h0000, 16'h0000};
		@(posedge mclk);
		{aamRecommended, aamCurrent} <= 16'h80FE;
		maxLba48 <= 48'h1234_5678_9ABC;
		{securityLevelMax, securityFlags} <= 7'h6A;
		{cfaWordValid, cfaRequired, cfaDisabled, cfaMaxCurrent} <= 15'h60F5;
		otherByteSum <= 8'h37;
		acc = 8'h37 + 8'hA5;
		for (int i = 0; i < 13; i++) begin
			rdChk(w[i], e[i]);
			acc = acc + e[i][15:8] + e[i][7:0];
		end
		rdChk(8'hFF, {8'h00 - acc, 8'hA5});
		$display("words done");
	endtask
	task report_and_stop;
		$display("Checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge mclk);
		rstn <= 1'b1;
		t_dev0;
		t_dev1;
		t_freeze;
		t_words;
		report_and_stop;
	end
	// Whole run is about a hundred cycles, so this only trips on a hang
	initial begin
		#20000;
		num_errors++;
		report_and_stop;
	end
endmodule // identify_data_upper_words_test
